// ===== verilog/epi_consts.svh
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH

// Pin widths of the memory part, then counter widths
`define EPI_AW 15
`define EPI_DW 16
`define EPI_CODE_W 8
`define EPI_CNT_W 16
`define EPI_PULSE_CNT_W 8

// System clock period in ns
`define EPI_CLK_NS 10

// Read timing, ns
`define EPI_ACCESS_NS 100
`define EPI_READ_OE_NS 40
`define EPI_READ_FLOAT_NS 30

// Program and verify timing, ns
`define EPI_SETUP_NS 2000
`define EPI_HOLD_NS 2000
`define EPI_VERIFY_OE_NS 100
`define EPI_VERIFY_FLOAT_NS 130
`define EPI_PULSE_NS 100000

// Retry limit for program pulses
`define EPI_MAX_PULSES 25

// Least time in ns to whole cycles, never below one
`define EPI_CYC_UP(ns) ((((ns) + `EPI_CLK_NS - 1) / `EPI_CLK_NS) < 1 ? 1 : \
  (((ns) + `EPI_CLK_NS - 1) / `EPI_CLK_NS))

`endif

// ===== verilog/epi_pkg.sv
`include "epi_consts.svh"

package epi_pkg;

  // Host commands
  typedef enum logic [1:0] {
    EPI_OP_READ = 2'h0,
    EPI_OP_PROG = 2'h1,
    EPI_OP_IDENT = 2'h2,
    EPI_OP_RSVD = 2'h3
  } epi_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    EPI_IDLE = 3'h0,
    EPI_SETUP = 3'h1,
    EPI_PULSE = 3'h2,
    EPI_HOLD = 3'h3,
    EPI_OESET = 3'h4,
    EPI_GATE = 3'h5,
    EPI_FLOAT = 3'h6,
    EPI_DONE = 3'h7
  } epi_state_t;

  // Whole state of the controller
  typedef struct packed {
    epi_state_t state;
    epi_op_t op;
    logic [`EPI_AW-1:0] addr;
    logic [`EPI_DW-1:0] wdata;
    logic [`EPI_DW-1:0] rdata;
    logic [`EPI_PULSE_CNT_W-1:0] pulses;
    logic cs_n;
    logic og_n;
    logic ps_n;
    logic dq_oe;
    logic vpp_en;
    logic vcc_hi;
    logic sig_hv;
    logic tmr_load;
    logic [`EPI_CNT_W-1:0] tmr_val;
    logic rsp_valid;
    logic rsp_pass;
    logic ready;
  } epi_regs_t;

endpackage

// ===== verilog/epi_timer.sv
`timescale 1ns/1ps
`include "epi_consts.svh"

module epi_timer
  import epi_pkg::*;
#(
  parameter int CW = `EPI_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [CW-1:0] load_val,
  output logic done
);

  // Timer state
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } epi_tmr_t;

  epi_tmr_t r;
  epi_tmr_t next_r;

  // Count down; one-cycle pulse when the count runs out
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (load) begin
      next_r.cnt = load_val;
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - CW'(1);
      next_r.done = (r.cnt == CW'(1));
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

endmodule

// ===== verilog/epi_host.sv
`timescale 1ns/1ps
`include "epi_consts.svh"

// Notes on behaviour
// (R1) Data only when select and gate low
// (R2) Address access equals select access time
// (R3) Gate data valid after gate delay
// (R4) Gate may lag select by access minus gate
// (R5) Float delay from first deasserted control
// (R6) Select high means standby, pins floating
// (R7) Select per device, gate shared strobe
// (R8) Erased bits read one
// (R9) Programmed zero only cleared by UV
// (R10) Program: high supply, select, strobe low
// (R11) Full word and address during programming
// (R12) Repeat pulses with verify until match
// (R13) Device margin read during program/verify
// (R14) No overprogram pulse after passing verify
// (R15) Select pulse programs only that device
// (R16) Select high ignores program pulses
// (R17) Verify read after programming location
// (R18) Verify: select, gate low, strobe high, supplies
// (R19) Identification: high voltage on signature line
// (R20) Low address bit picks maker or type
// (R21) Other address lines low in identification
// (R22) Codes on lower eight data pins
// (R23) Program pulse 95 to 105 microseconds
// (R24) Read is lookup of address into array
// (R25) Upper identification byte taken as zero
module epi_host
  import epi_pkg::*;
#(
  parameter logic [`EPI_CNT_W-1:0] PULSE_CYC =
    `EPI_CNT_W'(`EPI_PULSE_NS / `EPI_CLK_NS),
  parameter logic [`EPI_PULSE_CNT_W-1:0] MAX_PULSES =
    `EPI_PULSE_CNT_W'(`EPI_MAX_PULSES)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire epi_op_t cmd_op,
  input wire logic [`EPI_AW-1:0] cmd_addr,
  input wire logic [`EPI_DW-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [`EPI_DW-1:0] rsp_data,
  output logic rsp_pass,
  output logic [`EPI_PULSE_CNT_W-1:0] rsp_pulses,
  output logic [`EPI_AW-1:0] addr_pins,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic program_strobe_n,
  output logic [`EPI_DW-1:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic [`EPI_DW-1:0] data_pins_in,
  output logic vpp_program_en,
  output logic vcc_raise_en,
  output logic signature_select_line
);

  // Cycle counts derived from the printed times
  localparam logic [`EPI_CNT_W-1:0] READ_LEAD_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_ACCESS_NS - `EPI_READ_OE_NS));
  localparam logic [`EPI_CNT_W-1:0] READ_OE_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_READ_OE_NS));
  localparam logic [`EPI_CNT_W-1:0] READ_FLOAT_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_READ_FLOAT_NS));
  localparam logic [`EPI_CNT_W-1:0] SETUP_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_SETUP_NS));
  localparam logic [`EPI_CNT_W-1:0] HOLD_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_HOLD_NS));
  localparam logic [`EPI_CNT_W-1:0] VER_OE_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_VERIFY_OE_NS));
  localparam logic [`EPI_CNT_W-1:0] VER_FLOAT_CYC =
    `EPI_CNT_W'(`EPI_CYC_UP(`EPI_VERIFY_FLOAT_NS));

  epi_regs_t r; // Registered state
  epi_regs_t next_r; // Next state
  logic tmr_done; // Wait of the current state has run out

  // Wait timer, restarted on every state change except those into EPI_DONE and EPI_IDLE
  epi_timer #(
    .CW(`EPI_CNT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(r.tmr_load),
    .load_val(r.tmr_val),
    .done(tmr_done)
  );

  // Gate delay for the current operation
  function automatic logic [`EPI_CNT_W-1:0] oe_cyc(input epi_op_t op);
    oe_cyc = (op == EPI_OP_PROG) ? VER_OE_CYC : READ_OE_CYC;
  endfunction

  // Float delay for the current operation
  function automatic logic [`EPI_CNT_W-1:0] float_cyc(input epi_op_t op);
    float_cyc = (op == EPI_OP_PROG) ? VER_FLOAT_CYC : READ_FLOAT_CYC;
  endfunction

  // Sequencer
  always_comb begin
    next_r = r;
    next_r.tmr_load = 1'b0;
    next_r.rsp_valid = 1'b0;
    unique case (r.state)
      // Wait for a command
      EPI_IDLE: begin
        if (cmd_valid && cmd_op != EPI_OP_RSVD) begin
          next_r.op = cmd_op;
          next_r.wdata = cmd_data;
          next_r.pulses = '0;
          next_r.rsp_pass = 1'b0;
          next_r.ready = 1'b0;
          next_r.cs_n = 1'b0; // see (R7)
          next_r.state = EPI_SETUP;
          next_r.tmr_load = 1'b1;
          next_r.tmr_val = READ_LEAD_CYC; // see (R4)
          next_r.addr = cmd_addr;
          if (cmd_op == EPI_OP_IDENT) begin
            // Only the byte select bit may be high
            next_r.addr = '0; // see (R21)
            next_r.addr[0] = cmd_addr[0]; // see (R20)
            next_r.sig_hv = 1'b1; // see (R19)
            next_r.tmr_val = SETUP_CYC;
          end else if (cmd_op == EPI_OP_PROG) begin
            next_r.vpp_en = 1'b1; // see (R10)
            next_r.vcc_hi = 1'b1;
            next_r.dq_oe = 1'b1; // see (R11)
            next_r.tmr_val = SETUP_CYC;
          end
        end
      end
      // Address, select, supplies and data settle
      EPI_SETUP: begin
        if (tmr_done) begin
          next_r.tmr_load = 1'b1;
          if (r.op == EPI_OP_PROG) begin
            next_r.ps_n = 1'b0; // see (R10) (R15)
            next_r.pulses = r.pulses + `EPI_PULSE_CNT_W'(1);
            next_r.tmr_val = PULSE_CYC; // see (R23)
            next_r.state = EPI_PULSE;
          end else begin
            next_r.og_n = 1'b0; // see (R1) (R3)
            next_r.tmr_val = oe_cyc(r.op);
            next_r.state = EPI_GATE;
          end
        end
      end
      // Program pulse in progress
      EPI_PULSE: begin
        if (tmr_done) begin
          next_r.ps_n = 1'b1;
          next_r.tmr_load = 1'b1;
          next_r.tmr_val = HOLD_CYC;
          next_r.state = EPI_HOLD;
        end
      end
      // Data held after the pulse, then released
      EPI_HOLD: begin
        if (tmr_done) begin
          next_r.dq_oe = 1'b0;
          next_r.tmr_load = 1'b1;
          next_r.tmr_val = SETUP_CYC;
          next_r.state = EPI_OESET;
        end
      end
      // Gate setup before the verify read
      EPI_OESET: begin
        if (tmr_done) begin
          next_r.og_n = 1'b0; // see (R17) (R18)
          next_r.tmr_load = 1'b1;
          next_r.tmr_val = VER_OE_CYC;
          next_r.state = EPI_GATE;
        end
      end
      // Gate low; sample once the data is valid
      EPI_GATE: begin
        if (tmr_done) begin
          next_r.rdata = data_pins_in; // see (R2) (R24)
          if (r.op == EPI_OP_IDENT) begin
            next_r.rdata[`EPI_DW-1:`EPI_CODE_W] = '0; // see (R22) (R25)
          end
          next_r.og_n = 1'b1; // see (R5)
          next_r.tmr_load = 1'b1;
          next_r.tmr_val = float_cyc(r.op);
          next_r.state = EPI_FLOAT;
        end
      end
      // Wait for the part to stop driving
      EPI_FLOAT: begin
        if (tmr_done) begin
          next_r.state = EPI_DONE;
          if (r.op == EPI_OP_PROG) begin
            if (r.rdata == r.wdata) begin
              next_r.rsp_pass = 1'b1; // see (R13) (R14)
            end else if (r.pulses != MAX_PULSES) begin
              // Drive the word again for another pulse
              next_r.dq_oe = 1'b1; // see (R12)
              next_r.tmr_load = 1'b1;
              next_r.tmr_val = SETUP_CYC;
              next_r.state = EPI_SETUP;
            end
          end else begin
            next_r.rsp_pass = 1'b1;
          end
        end
      end
      // Release the part and answer the host
      EPI_DONE: begin
        next_r.cs_n = 1'b1; // see (R6) (R16)
        next_r.vpp_en = 1'b0;
        next_r.vcc_hi = 1'b0;
        next_r.sig_hv = 1'b0;
        next_r.addr = '0;
        next_r.rsp_valid = 1'b1;
        next_r.ready = 1'b1;
        next_r.state = EPI_IDLE;
      end
    endcase
  end

  // State register; pins idle in standby after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.state <= EPI_IDLE;
      r.cs_n <= 1'b1;
      r.og_n <= 1'b1;
      r.ps_n <= 1'b1;
      r.ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign cmd_ready = r.ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rdata; // see (R8) (R9)
  assign rsp_pass = r.rsp_pass;
  assign rsp_pulses = r.pulses;
  assign addr_pins = r.addr;
  assign chip_select_n = r.cs_n;
  assign output_gate_n = r.og_n;
  assign program_strobe_n = r.ps_n;
  assign data_pins_out = r.wdata;
  assign data_pins_oe = r.dq_oe;
  assign vpp_program_en = r.vpp_en;
  assign vcc_raise_en = r.vcc_hi;
  assign signature_select_line = r.sig_hv;

endmodule

// ===== testbench/epi_host_assertions.sv
`timescale 1ns/1ps
`include "epi_consts.svh"

module epi_host_assertions
  import epi_pkg::*;
#(
  parameter logic [`EPI_CNT_W-1:0] PULSE_CYC = 16'h2710,
  parameter logic [`EPI_PULSE_CNT_W-1:0] MAX_PULSES = 8'h19
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rsp_valid,
  input wire logic rsp_pass,
  input wire logic [`EPI_PULSE_CNT_W-1:0] rsp_pulses,
  input wire logic [`EPI_AW-1:0] addr_pins,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic program_strobe_n,
  input wire logic data_pins_oe,
  input wire logic vpp_program_en,
  input wire logic vcc_raise_en,
  input wire logic signature_select_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [`EPI_CNT_W-1:0] low_cnt; // Cycles the strobe has been low
  // Measures each program strobe pulse
  always_ff @(posedge clk_sys) begin
    if (rst || program_strobe_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 1'b1;
    end
  end
  property p_gate;
    !output_gate_n |-> !chip_select_n && !data_pins_oe;
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate without select");
  property p_lead;
    $fell(output_gate_n) |-> $past(chip_select_n, 6) == 1'b0;
  endproperty
  a_lead: assert property (p_lead)
    else $error("gate too early");
  // Read float: part may still drive for three cycles after the gate
  property p_float;
    $rose(output_gate_n) |-> !data_pins_oe [*3];
  endproperty
  a_float: assert property (p_float)
    else $error("pins driven in read float time");
  // Verify float is longer: thirteen cycles before driving again
  property p_vfloat;
    $rose(output_gate_n) && vpp_program_en |->
      !data_pins_oe [*8] ##1 !data_pins_oe [*5];
  endproperty
  a_vfloat: assert property (p_vfloat)
    else $error("pins driven in verify float time");
  property p_idle;
    chip_select_n |-> output_gate_n && program_strobe_n &&
      !vpp_program_en && !signature_select_line;
  endproperty
  a_idle: assert property (p_idle)
    else $error("activity while deselected");
  property p_prog;
    !program_strobe_n |-> !chip_select_n && vpp_program_en &&
      vcc_raise_en && data_pins_oe;
  endproperty
  a_prog: assert property (p_prog)
    else $error("strobe without program set");
  property p_verify;
    !output_gate_n && vpp_program_en |-> vcc_raise_en && program_strobe_n;
  endproperty
  a_verify: assert property (p_verify)
    else $error("bad verify setup");
  property p_ident;
    signature_select_line |-> !vpp_program_en && addr_pins[14:1] == 14'h0;
  endproperty
  a_ident: assert property (p_ident)
    else $error("bad identify setup");
  property p_pulse;
    $rose(program_strobe_n) |->
      low_cnt >= PULSE_CYC && low_cnt <= PULSE_CYC + 16'h2;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe pulse width");
  // A failed answer only after the whole pulse budget was spent
  property p_max;
    rsp_valid |-> rsp_pulses <= MAX_PULSES &&
      (rsp_pass || rsp_pulses == MAX_PULSES);
  endproperty
  a_max: assert property (p_max)
    else $error("pulse count wrong for the answer");
endmodule

bind epi_host epi_host_assertions #(
  .PULSE_CYC(PULSE_CYC),
  .MAX_PULSES(MAX_PULSES)
) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .rsp_valid(rsp_valid),
  .rsp_pass(rsp_pass),
  .rsp_pulses(rsp_pulses),
  .addr_pins(addr_pins),
  .chip_select_n(chip_select_n),
  .output_gate_n(output_gate_n),
  .program_strobe_n(program_strobe_n),
  .data_pins_oe(data_pins_oe),
  .vpp_program_en(vpp_program_en),
  .vcc_raise_en(vcc_raise_en),
  .signature_select_line(signature_select_line)
);

// ===== testbench/epi_mem_model.sv
`timescale 1ns/1ps

module epi_mem_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hc3 // Arbitrary value
) (
  input wire logic [14:0] addr_pins,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic program_strobe_n,
  input wire logic [15:0] data_pins_out,
  input wire logic data_pins_oe,
  input wire logic vpp_program_en,
  input wire logic vcc_raise_en,
  input wire logic signature_select_line,
  input wire logic [3:0] need,
  output logic [15:0] data_pins_in
);
  logic [15:0] mem [0:32767]; // Cell array
  logic [3:0] hits; // Pulses taken for this word
  logic [15:0] rd; // Word the part would show
  logic [15:0] last; // Last word driven
  logic drv; // Part drives the pins
  // Every cell starts erased
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    last = 16'h0;
    hits = 4'h0;
  end
  // Pulses count only with select low; cells only go to zero
  always @(posedge program_strobe_n or posedge chip_select_n) begin
    if (chip_select_n) begin
      hits = 4'h0;
    end else if (vpp_program_en && vcc_raise_en && data_pins_oe) begin
      hits = hits + 4'h1;
      if (hits >= need) begin
        mem[addr_pins] = mem[addr_pins] & data_pins_out;
        hits = 4'h0;
      end
    end
  end
  // Read word: codes in identify mode, else the margin read cell
  always @* begin
    drv = !chip_select_n && !output_gate_n && program_strobe_n;
    if (signature_select_line) begin
      rd = {8'h00, addr_pins[0] ? DEV_CODE : MFR_CODE};
    end else begin
      rd = mem[addr_pins];
    end
    if (drv) last = rd;
  end
  // Data after gate delay; released pins show the inverse of the last word
  assign #40 data_pins_in = (data_pins_oe && drv) ? 16'hxxxx :
    data_pins_oe ? data_pins_out : drv ? rd : ~last;
endmodule

// ===== testbench/epi_host_tb.sv
`timescale 1ns/1ps
`include "epi_consts.svh"

module epi_host_tb;
  import epi_pkg::*;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary maker code
  localparam logic [7:0] DEV = 8'hc3; // Arbitrary type code
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  epi_op_t cmd_op = EPI_OP_READ;
  logic [14:0] cmd_addr = 15'h0;
  logic [15:0] cmd_data = 16'h0;
  logic [3:0] need = 4'h1; // Pulses the part needs per word
  logic cmd_ready, rsp_valid, rsp_pass, chip_select_n, output_gate_n;
  logic program_strobe_n, data_pins_oe, vpp_program_en, vcc_raise_en;
  logic signature_select_line;
  logic [15:0] rsp_data, data_pins_out, data_pins_in;
  logic [7:0] rsp_pulses;
  logic [14:0] addr_pins;
  int err_count = 0;
  int cmp_count = 0;
  int n; // Cycles to the answer
  // Clock
  always #5 clk_sys = ~clk_sys;
  epi_host #(.PULSE_CYC(16'h0014), .MAX_PULSES(8'h03)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .cmd_addr(cmd_addr),
    .cmd_data(cmd_data),
    .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .rsp_pass(rsp_pass),
    .rsp_pulses(rsp_pulses),
    .addr_pins(addr_pins),
    .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n),
    .program_strobe_n(program_strobe_n),
    .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe),
    .data_pins_in(data_pins_in),
    .vpp_program_en(vpp_program_en),
    .vcc_raise_en(vcc_raise_en),
    .signature_select_line(signature_select_line)
  );
  epi_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (
    .addr_pins(addr_pins),
    .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n),
    .program_strobe_n(program_strobe_n),
    .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe),
    .vpp_program_en(vpp_program_en),
    .vcc_raise_en(vcc_raise_en),
    .signature_select_line(signature_select_line),
    .need(need),
    .data_pins_in(data_pins_in)
  );
  // Compares one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Issues one command and waits for its answer
  task automatic cmd(input epi_op_t op, input logic [14:0] a,
      input logic [15:0] d);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(16'(n < 4000), 16'h1);
  endtask
  // Programs a word, checks the result, reads it back
  task automatic prog(input logic [3:0] k, input logic [14:0] a,
      input logic [15:0] d, input logic [7:0] np, input logic ok,
      input logic [15:0] back);
    need = k;
    cmd(EPI_OP_PROG, a, d);
    chk(16'(rsp_pass), 16'(ok));
    chk(16'(rsp_pulses), 16'(np));
    cmd(EPI_OP_READ, a, 16'h0);
    chk(rsp_data, back);
  endtask
  // Erased words at both ends, with read latency
  task automatic t_erased;
    cmd(EPI_OP_READ, 15'h0000, 16'h0);
    chk(16'(n), 16'h14);
    chk(rsp_data, 16'hffff);
    chk(16'(rsp_pass), 16'h1);
    cmd(EPI_OP_READ, 15'h7fff, 16'h0);
    chk(rsp_data, 16'hffff);
  endtask
  // Prompt part, then a part that needs a second pulse
  task automatic t_prog;
    prog(4'h1, 15'h1234, 16'ha5a5, 8'h1, 1'b1, 16'ha5a5);
    prog(4'h2, 15'h0005, 16'h0f0f, 8'h2, 1'b1, 16'h0f0f);
  endtask
  // Pulse limit reached; zeros cannot be set back to one
  task automatic t_prog_bad;
    prog(4'h5, 15'h0006, 16'h0000, 8'h3, 1'b0, 16'hffff);
    prog(4'h1, 15'h1234, 16'hffff, 8'h3, 1'b0, 16'ha5a5);
  endtask
  // Both codes, upper address bits set by the caller
  task automatic t_ident;
    cmd(EPI_OP_IDENT, 15'h7ffe, 16'h0);
    chk(rsp_data, {8'h00, MFR});
    cmd(EPI_OP_IDENT, 15'h7fff, 16'h0);
    chk(rsp_data, {8'h00, DEV});
  endtask
  // Reserved op leaves the part in standby
  task automatic t_rsvd;
    cmd_op = EPI_OP_RSVD;
    cmd_valid = 1'b1;
    repeat (30) begin
      @(posedge clk_sys);
      #1 chk({13'h0, cmd_ready, chip_select_n, rsp_valid}, 16'h6);
    end
    cmd_valid = 1'b0;
    @(posedge clk_sys);
    #1 cmd(EPI_OP_READ, 15'h0005, 16'h0);
    chk(rsp_data, 16'h0f0f);
  endtask
  // Prints the verdict and ends the run
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    err_count++;
    summarize;
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_erased;
    t_prog;
    t_prog_bad;
    t_ident;
    t_rsvd;
    summarize;
  end
endmodule
